// ===== include/gnb_map.vh
// gnb_map.vh: register indices, reset values and field positions for the bridge
// assumes inclusion by bare name from core files
`ifndef GNB_MAP_VH
`define GNB_MAP_VH
`define GNB_REG_BITFILE   8'h06
`define GNB_REG_RTLVER    8'h07
`define GNB_REG_CTRLH     8'h09
`define GNB_REG_USERSW    8'h22
`define GNB_REG_LAST      8'h22
`define GNB_APB_CTRLH     12'h000
`define GNB_APB_STATUS    12'h004
`define GNB_CTRLH_RESET   8'h70
`define GNB_WP_BIT        4
`define GNB_LED0_BIT      5
`define GNB_LED1_BIT      6
`define GNB_LEDEN_BIT     7
`define GNB_CMD_NOP       2'b00
`define GNB_CMD_ADDR      2'b01
`define GNB_CMD_READ      2'b10
`define GNB_CMD_WRITE     2'b11
`define GNB_VER_DEFAULT   8'h01
`define GNB_STRETCH_CYC   4'h1
`endif

// ===== core/gnb_reg_mem.v
// gnb_reg_mem.v: small configuration register store, registered read data
// assumes one clock, writes and reads from the bridge core only
`timescale 1ns/1ns
`include "gnb_map.vh"
module gnb_reg_mem #(
  parameter AW = 8
) (
  input  wire          clk_sys,
  input  wire          arst_n,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [7:0]    wrData,
  input  wire [AW-1:0] rdAddr,
  input  wire [7:0]    userSw,
  output reg  [7:0]    rdData_q,
  output reg  [7:0]    ctrlHigh_q
);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrlHigh_q <= `GNB_CTRLH_RESET;
      rdData_q   <= 8'h00;
    end else begin
      if (wrEn && wrAddr == `GNB_REG_CTRLH) begin
        ctrlHigh_q <= wrData;
      end
      case (rdAddr)
        `GNB_REG_BITFILE: rdData_q <= `GNB_VER_DEFAULT;
        `GNB_REG_RTLVER:  rdData_q <= `GNB_VER_DEFAULT;
        `GNB_REG_CTRLH:   rdData_q <= ctrlHigh_q;
        `GNB_REG_USERSW:  rdData_q <= userSw;
        default:          rdData_q <= 8'h00;
      endcase
    end
  end
endmodule

// ===== core/gnb_bridge.v
// gnb_bridge.v: mode-switched register bus / flash pass-through bridge
// assumes processor gp lines are asynchronous; apb master on clk_sys
// Function
// [RULE1] mode low selects strobed register bus
// [RULE2] register access only in normal mode
// [RULE3] mode high maps lines to flash pins
// [RULE4] flash write-protect from control bit four
// [RULE5] mode honoured only after boot done
// [RULE6] low eight lines form shared bidirectional bus
// [RULE7] command 00 nop 01 addr 10 read 11 write
// [RULE8] processor strobe times every bus cycle
// [RULE9] ready low stretches read or write
// [RULE10] processor ignores ready on addr and nop
// [RULE11] lines twelve and thirteen unused normally
// [RULE12] line fifteen follows bridge interrupt always
// [RULE13] pass-through links low lines to flash data
// [RULE14] line eight cle, line nine ale
// [RULE15] ten write, twelve read, thirteen chip select
// [RULE16] line eleven driven from flash ready/busy
// [RULE17] register space spans 0x00 to 0x22
// [RULE18] software unprotects before entering pass-through
// [RULE19] last address retained for later cycles
// [RULE20] drive data only during read strobe
// [RULE21] write-protect bit one disables protection
// [RULE22] strobe, command, mode pass two-stage synchronisers
// [RULE23] pass-through ignores strobe, data driver off; code drives flash data onto the bus when both spare lines are low
`timescale 1ns/1ns
`include "gnb_map.vh"
module gnb_bridge #(
  parameter AW = 8
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        bootDone,
  input  wire [7:0]  busDataIn,
  output wire [7:0]  busDataOut,
  output wire        busDataOe_n,
  input  wire [1:0]  commandField,
  input  wire        strobeLine,
  output wire        readyOutLine,
  input  wire        spareLineA,
  input  wire        spareLineB,
  input  wire        modeSelectLine,
  output wire        bridgeIrqOut,
  input  wire        bridgeIrqIn,
  input  wire [7:0]  flashDataIn,
  output wire [7:0]  flashDataOut,
  output wire        flashDataOe_n,
  output wire        flashCle,
  output wire        flashAle,
  output wire        flashWriteStrobe,
  output wire        flashReadStrobe,
  output wire        flashChipSelect,
  output wire        flashWriteProtect,
  input  wire        flashReadyBusy,
  output wire        userLed0,
  output wire        userLed1,
  input  wire [7:0]  userSw,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr
);
  reg  [1:0]    stbSync_q;
  reg  [1:0]    cmdS1_q;
  reg  [1:0]    cmdS2_q;
  reg  [1:0]    modeSync_q;
  reg  [1:0]    bootSync_q;
  reg           stbPrev_q;
  reg  [AW-1:0] addr_q;
  reg  [7:0]    wrData_q;
  reg           wrEn_q;
  reg           rdy_q;
  reg  [3:0]    stretch_q;
  reg  [7:0]    dataIn1_q;
  reg  [7:0]    dataIn2_q;
  reg           apbWr_q;
  reg  [AW-1:0] apbRdAddr_q;
  reg           apbPend_q;
  wire          stbS;
  wire          modeS;
  wire          passMode;
  wire          normMode;
  wire          stbRise;
  wire [7:0]    rdData;
  wire [7:0]    ctrlHigh;
  wire          apbAcc;
  wire          flashRdActive;
  wire          memWrEn;
  wire [AW-1:0] memWrAddr;
  wire [7:0]    memWrData;
  wire [AW-1:0] memRdAddr;

  function inMap;
    input [AW-1:0] a;
    begin
      inMap = (a <= `GNB_REG_LAST); // [RULE17]
    end
  endfunction

  // first stages only feed second stages
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stbSync_q  <= 2'b00;
      cmdS1_q    <= 2'b00;
      cmdS2_q    <= 2'b00;
      modeSync_q <= 2'b00;
      bootSync_q <= 2'b00;
      dataIn1_q  <= 8'h00;
      dataIn2_q  <= 8'h00;
    end else begin
      stbSync_q  <= {stbSync_q[0], strobeLine}; // [RULE22]
      cmdS1_q    <= commandField; // [RULE22]
      cmdS2_q    <= cmdS1_q;
      modeSync_q <= {modeSync_q[0], modeSelectLine}; // [RULE22]
      bootSync_q <= {bootSync_q[0], bootDone};
      dataIn1_q  <= busDataIn;
      dataIn2_q  <= dataIn1_q;
    end
  end

  assign stbS     = stbSync_q[1];
  assign modeS    = modeSync_q[1];
  // before boot the lines carry straps, so stay in normal mode
  assign passMode = bootSync_q[1] & modeS; // [RULE5]
  assign normMode = ~passMode; // [RULE1]
  assign stbRise  = stbS & ~stbPrev_q & normMode; // [RULE8] [RULE23]

  // strobe cycle engine: act on rising edge of the synced strobe
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stbPrev_q <= 1'b0;
      addr_q    <= {AW{1'b0}};
      wrData_q  <= 8'h00;
      wrEn_q    <= 1'b0;
      rdy_q     <= 1'b1;
      stretch_q <= 4'h0;
    end else begin
      stbPrev_q <= stbS;
      wrEn_q    <= 1'b0;
      if (stretch_q != 4'h0) begin
        stretch_q <= stretch_q - 4'h1;
        if (stretch_q == 4'h1) begin
          rdy_q <= 1'b1; // [RULE9]
        end
      end
      if (stbRise) begin // [RULE2]
        case (cmdS2_q) // [RULE7]
          `GNB_CMD_NOP: begin
          end
          `GNB_CMD_ADDR: begin
            addr_q <= dataIn2_q[AW-1:0]; // [RULE19]
          end
          `GNB_CMD_READ: begin
            // one extra cycle lets registered read data settle
            rdy_q     <= 1'b0; // [RULE9]
            stretch_q <= `GNB_STRETCH_CYC;
          end
          `GNB_CMD_WRITE: begin
            wrData_q  <= dataIn2_q;
            wrEn_q    <= inMap(addr_q); // [RULE19]
            rdy_q     <= 1'b0; // [RULE9]
            stretch_q <= `GNB_STRETCH_CYC;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // apb slave: one wait state; read data come from ctrlHigh or the status bits
  assign apbAcc   = psel & penable;
  assign pready   = apbPend_q;
  assign pslverr  = 1'b0;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      apbPend_q   <= 1'b0;
      apbWr_q     <= 1'b0;
      apbRdAddr_q <= {AW{1'b0}};
      prdata      <= 32'h0000_0000;
    end else begin
      apbWr_q   <= 1'b0;
      apbPend_q <= apbAcc & ~apbPend_q;
      if (psel && !penable) begin
        apbRdAddr_q <= (paddr == `GNB_APB_CTRLH) ? `GNB_REG_CTRLH :
                       `GNB_REG_USERSW;
      end
      // write lands on the edge that samples pready high, not before
      apbWr_q <= apbAcc && !apbPend_q && pwrite &&
                 paddr == `GNB_APB_CTRLH;
      if (apbAcc && !apbPend_q && !pwrite) begin
        case (paddr)
          `GNB_APB_CTRLH:  prdata <= {24'h00_0000, ctrlHigh};
          `GNB_APB_STATUS: prdata <= {28'h000_0000, flashReadyBusy,
                                      passMode, modeS, rdy_q};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // gpio write wins; apb write dropped when both collide
  assign memWrEn   = wrEn_q | apbWr_q;
  assign memWrAddr = wrEn_q ? addr_q : `GNB_REG_CTRLH;
  assign memWrData = wrEn_q ? wrData_q : pwdata[7:0];
  assign memRdAddr = (apbPend_q || (psel && penable)) ? apbRdAddr_q :
                     addr_q;

  gnb_reg_mem #(
    .AW(AW)
  ) uMem (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .wrEn       (memWrEn),
    .wrAddr     (memWrAddr),
    .wrData     (memWrData),
    .rdAddr     (memRdAddr),
    .userSw     (userSw),
    .rdData_q   (rdData),
    .ctrlHigh_q (ctrlHigh)
  );

  // normal-mode bus drive, combinational from synced strobe and cmd
  assign busDataOut  = passMode ? flashDataIn : rdData; // [RULE13]
  assign flashRdActive = ~spareLineA & ~spareLineB;
  assign busDataOe_n = passMode ? ~flashRdActive :
                       ~(stbS & (cmdS2_q == `GNB_CMD_READ)); // [RULE20] [RULE6]
  assign readyOutLine = passMode ? flashReadyBusy : rdy_q; // [RULE16] [RULE9]
  assign bridgeIrqOut = bridgeIrqIn; // [RULE12]

  // pass-through: straight wiring; idle flash pins when normal
  // spare lines are ignored in normal mode
  assign flashDataOut     = busDataIn; // [RULE13]
  assign flashDataOe_n    = ~(passMode & spareLineA); // [RULE13] [RULE3]
  assign flashCle         = passMode & commandField[0]; // [RULE14]
  assign flashAle         = passMode & commandField[1]; // [RULE14]
  assign flashWriteStrobe = passMode ? strobeLine : 1'b1; // [RULE15]
  assign flashReadStrobe  = passMode ? spareLineA : 1'b1; // [RULE15] [RULE11]
  assign flashChipSelect  = passMode ? spareLineB : 1'b1; // [RULE15] [RULE11]
  // 1 disables protection, so pin is high when bit is set
  assign flashWriteProtect = ctrlHigh[`GNB_WP_BIT]; // [RULE4] [RULE21] [RULE18]
  assign userLed0 = ctrlHigh[`GNB_LEDEN_BIT] ? ctrlHigh[`GNB_LED0_BIT] : 1'b1;
  assign userLed1 = ctrlHigh[`GNB_LEDEN_BIT] ? ctrlHigh[`GNB_LED1_BIT] : 1'b1;
endmodule

// ===== tb/gnb_bridge_sva.sv
// gnb_bridge_sva.sv: port assertions for gnb_bridge
// assumes bind by name; one clock domain
`timescale 1ns/1ns
module gnb_bridge_sva (
  input wire       clk_sys,
  input wire       arst_n,
  input wire       bootDone,
  input wire       modeSelectLine,
  input wire       strobeLine,
  input wire [1:0] commandField,
  input wire       spareLineA,
  input wire       spareLineB,
  input wire       busDataOe_n,
  input wire       readyOutLine,
  input wire       bridgeIrqIn,
  input wire       bridgeIrqOut,
  input wire       flashReadyBusy,
  input wire       flashCle,
  input wire       flashAle,
  input wire       flashWriteStrobe,
  input wire       flashReadStrobe,
  input wire       flashChipSelect,
  input wire       flashWriteProtect,
  input wire [7:0] busDataIn,
  input wire [7:0] flashDataOut,
  input wire       flashDataOe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // six cycles cover the synchronisers and the mode register
  sequence passHeld;
    (modeSelectLine && bootDone) [*6];
  endsequence
  sequence normHeld;
    (!modeSelectLine || !bootDone) [*6];
  endsequence
  irq_follow_a: assert property (bridgeIrqOut == bridgeIrqIn)
    else $error("irq out wrong");
  pass_data_a: assert property (passHeld |->
    flashDataOut == busDataIn && flashDataOe_n == !spareLineA)
    else $error("flash data path wrong");
  pass_map_a: assert property (passHeld |->
    flashCle == commandField[0] && flashAle == commandField[1] &&
    flashWriteStrobe == strobeLine && flashReadStrobe == spareLineA &&
    flashChipSelect == spareLineB) else $error("flash map wrong");
  pass_ready_a: assert property (passHeld |->
    readyOutLine == flashReadyBusy) else $error("ready map wrong");
  pass_drv_a: assert property (passHeld ##0 spareLineA |->
    busDataOe_n) else $error("driver on in pass mode");
  read_drive_a: assert property (normHeld ##0
    (!strobeLine || commandField != 2'h2) [*4] |-> busDataOe_n)
    else $error("bus driven outside read");
  ready_pulse_a: assert property (normHeld ##0
    $fell(readyOutLine) |=> readyOutLine) else $error("ready held low");
  norm_idle_a: assert property (normHeld |->
    flashWriteStrobe && flashReadStrobe && flashChipSelect &&
    !flashCle && !flashAle) else $error("flash pins active");
  wp_reset_a: assert property ($rose(arst_n) |->
    flashWriteProtect) else $error("write protect reset wrong");
endmodule
bind gnb_bridge gnb_bridge_sva i_gnb_bridge_sva (.*);

// ===== tb/gnb_gp_master.sv
// gnb_gp_master.sv: processor end of the strobed gp bus
// assumes cyc is called right after a rising edge
`timescale 1ns/1ns
module gnb_gp_master (
  input  wire        clk_sys,
  input  wire  [7:0] busDataOut,
  input  wire        busDataOe_n,
  input  wire        readyOutLine,
  output logic [1:0] commandField = 2'h0,
  output logic       strobeLine = 1'b0,
  output wire  [7:0] busDataIn
);
  logic [7:0] drv = 8'h00;
  logic       drvOn = 1'b0;
  int         timeouts = 0;
  // a released bus shows the inverse, never a held value
  assign busDataIn = !busDataOe_n ? busDataOut : drvOn ? drv : ~drv;
  task automatic cyc(input logic [1:0] c, input logic [7:0] d,
                     output logic [7:0] q);
    int n = 0;
    commandField <= c;
    drv <= d;
    drvOn <= c != 2'h2;
    @(posedge clk_sys);
    strobeLine <= 1'b1;
    repeat (6) @(posedge clk_sys);
    while (c[1] && !readyOutLine && n < 64) begin
      @(posedge clk_sys);
      n++;
    end
    timeouts += (n == 64);
    q = busDataIn;
    strobeLine <= 1'b0;
    repeat (6) @(posedge clk_sys);
    drvOn <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// ===== tb/tb_top.sv
// tb_top.sv: self-checking bench for gnb_bridge
// assumes gnb_gp_master as processor; apb driven here
`timescale 1ns/1ns
`include "gnb_map.vh"
module tb_top;
  logic        clk_sys = 1'b0, arst_n = 1'b0, bootDone = 1'b0;
  logic        modeSelectLine = 1'b0, bridgeIrqIn = 1'b0;
  logic        flashReadyBusy = 1'b1, spareLineA = 1'b1, spareLineB = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  flashDataIn = 8'h00, userSw = 8'h00, w;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q;
  wire  [31:0] prdata;
  wire  [7:0]  busDataIn, busDataOut, flashDataOut;
  wire  [1:0]  commandField;
  wire         busDataOe_n, strobeLine, readyOutLine, bridgeIrqOut, pready;
  wire         flashDataOe_n, flashCle, flashAle, flashWriteStrobe, pslverr;
  wire         flashReadStrobe, flashChipSelect, flashWriteProtect;
  wire         userLed0, userLed1;
  int          mismatches = 0, samplesChecked = 0, mdl [0:34];
  gnb_bridge i_gnb_bridge (.*);
  gnb_gp_master i_gnb_gp_master (.*);
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) bridgeIrqIn <= 1'($urandom);
  task automatic chk(input string nm, input logic [7:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    mismatches += i_gnb_gp_master.timeouts;
    if (mismatches == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (!pready && n < 32) begin
      @(posedge clk_sys);
      n++;
    end
    mismatches += (n == 32);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic gpw(input logic [7:0] a, d);
    i_gnb_gp_master.cyc(`GNB_CMD_ADDR, a, w);
    i_gnb_gp_master.cyc(`GNB_CMD_WRITE, d, w);
    if (a == 8'h09 && !(modeSelectLine && bootDone)) mdl[9] = d;
  endtask
  task automatic gpr(input logic [7:0] a, input bit setAddr);
    if (setAddr) i_gnb_gp_master.cyc(`GNB_CMD_ADDR, a, w);
    i_gnb_gp_master.cyc(`GNB_CMD_READ, 8'h00, w);
    chk("gp read", 8'(mdl[a]), w);
  endtask
  initial begin
    void'($urandom(32'hf901));
    userSw = 8'($urandom);
    mdl[6] = 1;
    mdl[7] = 1;
    mdl[9] = 'h70;
    mdl[34] = userSw;
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    bootDone <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, `GNB_APB_CTRLH, 32'h0000_0000);
    chk("apb ctrl", 8'h70, q[7:0]);
    for (int a = 6; a < 10; a++) gpr(8'(a), 1'b1);
    gpr(8'h22, 1'b1);
    repeat (3) begin
      gpw(8'h09, 8'($urandom));
      gpr(8'h09, 1'b0);
      chk("wp", {7'h00, mdl[9][4]}, {7'h00, flashWriteProtect});
      chk("led0", {7'h00, mdl[9][7] ? mdl[9][5] : 1'b1}, {7'h00, userLed0});
      chk("led1", {7'h00, mdl[9][7] ? mdl[9][6] : 1'b1}, {7'h00, userLed1});
    end
    gpw(8'h23, 8'h00);
    gpr(8'h09, 1'b1);
    apb(1'b1, `GNB_APB_CTRLH, {24'h00_0000, 8'($urandom)});
    mdl[9] = pwdata[7:0];
    gpr(8'h09, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("apb unmapped", 8'h00, q[7:0]);
    modeSelectLine <= 1'b1;
    repeat (8) @(posedge clk_sys);
    gpw(8'h09, ~8'(mdl[9]));
    chk("wp pass", {7'h00, mdl[9][4]}, {7'h00, flashWriteProtect});
    repeat (4) begin
      flashReadyBusy <= 1'($urandom);
      @(posedge clk_sys);
      chk("ready", {7'h00, flashReadyBusy}, {7'h00, readyOutLine});
    end
    flashReadyBusy <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, `GNB_APB_STATUS, 32'h0000_0000);
    chk("apb status", 8'h0f, q[7:0]);
    flashDataIn <= 8'($urandom);
    {spareLineA, spareLineB} <= 2'h0;
    i_gnb_gp_master.cyc(`GNB_CMD_READ, 8'h00, w);
    chk("flash data", flashDataIn, w);
    {spareLineA, spareLineB} <= 2'h3;
    modeSelectLine <= 1'b0;
    repeat (8) @(posedge clk_sys);
    gpr(8'h09, 1'b1);
    // mode line is ignored until boot is over
    bootDone <= 1'b0;
    modeSelectLine <= 1'b1;
    repeat (8) @(posedge clk_sys);
    gpw(8'h09, 8'($urandom));
    gpr(8'h09, 1'b0);
    stop_test;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    stop_test;
  end
endmodule
